// ==== verilog/led_channel_control_regs.sv ====
// Summary of operation
// - log bit makes channel current logarithmic
// - chip enable writable, cleared by low pin
// - hold: finish instruction, then stop
// - step: finish, advance counter, back to hold
// - continue: run instruction, advance, repeat
// - execute: run one instruction, back to hold
// - disable: no program, no direct duty
// - load: program writes accepted, counter cleared
// - run: program runs per execution field
// - direct: duty comes from duty register
// - three 8-bit duty registers, direct only
// - red current 8 bits, 0.1 mA steps
// - current registers reset to 17.5 mA
// - green current same coding as red
// - mode field change clears program counter
`timescale 1ns/1ps
`default_nettype none
`include "led_chan_consts.svh"

module led_channel_control_regs #(
  parameter logic [6:0] DEV_ADDR     = `DEV_ADDR_DFLT,
  parameter int         INSTR_CYCLES = `INSTR_CYCLES_DFLT
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       en_pin,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  output logic      [7:0] red_duty,
  output logic      [7:0] green_duty,
  output logic      [7:0] blue_duty,
  output logic      [7:0] red_current,
  output logic      [7:0] green_current,
  output logic      [3:0] red_prog_counter,
  output logic      [3:0] green_prog_counter,
  output logic      [3:0] blue_prog_counter,
  output logic            chip_active
);
  import led_chan_pkg::*;

  localparam int CHANS     = 3;
  localparam int PROG_SIZE = 96;

  function automatic logic [1:0] chan_field(
    input logic [7:0] v,
    input logic [1:0] c
  );
    case (c)
      2'd0:    return v[`RED_FIELD_LSB +: 2];
      2'd1:    return v[`GREEN_FIELD_LSB +: 2];
      default: return v[`BLUE_FIELD_LSB +: 2];
    endcase
  endfunction : chan_field

  function automatic logic [7:0] log_map(input logic [7:0] x);
    logic [15:0] sq;
    sq = 16'(x) * 16'(x);
    return sq[15:8] | {7'h00, (x != 8'h00) & (sq[15:8] == 8'h00)};
  endfunction : log_map

  // bus front end
  i2c_state_type state;
  reg_req_type   bus_req;
  logic          scl_q;
  logic          sda_q;
  logic          start_ev;
  logic          stop_ev;
  logic          scl_rise;
  logic          scl_fall;
  logic [3:0]    bit_cnt;
  logic [7:0]    shreg;
  logic          rw;
  logic          first;
  logic [6:0]    ptr;
  logic          drive_low;
  logic [7:0]    rd_data;

  // register bank
  logic          rst_n;
  logic [7:0]    run_ctrl_reg;
  logic [7:0]    run_ctrl_next;
  logic [7:0]    mode_sel_reg;
  logic [7:0]    duty_reg [CHANS];
  logic [7:0]    drive_reg [2];
  logic [7:0]    prog_mem [PROG_SIZE];
  logic [6:0]    prog_idx;
  logic          prog_hit;
  logic          chip_en;
  logic          log_en;
  logic [CHANS-1:0] mode_chg;
  logic [CHANS-1:0] hold_req;
  logic [3:0]    pc [CHANS];
  logic [7:0]    eng_duty [CHANS];
  logic [7:0]    duty_out [CHANS];

  assign rst_n   = nrst && en_pin;
  assign chip_en = run_ctrl_reg[`CHIP_EN_BIT];
  assign log_en  = run_ctrl_reg[`LOG_EN_BIT];

  assign start_ev = scl_q && scl_in && sda_q && !sda_in;
  assign stop_ev  = scl_q && scl_in && !sda_q && sda_in;
  assign scl_rise = !scl_q && scl_in;
  assign scl_fall = scl_q && !scl_in;

  assign sda_out  = 1'b0;
  assign sda_oe_n = !drive_low;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // byte-wide protocol engine with auto-incrementing pointer
  always_ff @(posedge sys_clk) begin
    bus_req.wr <= 1'b0;
    if (!nrst) begin
      state     <= I2C_IDLE;
      bus_req   <= '0;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      rw        <= 1'b0;
      first     <= 1'b0;
      ptr       <= 7'h00;
      drive_low <= 1'b0;
    end else if (start_ev) begin
      state     <= I2C_ADDR;
      bit_cnt   <= 4'h0;
      first     <= 1'b1;
      drive_low <= 1'b0;
    end else if (stop_ev) begin
      state     <= I2C_IDLE;
      drive_low <= 1'b0;
    end else if (scl_rise) begin
      if (state == I2C_ADDR || state == I2C_WR) begin
        shreg   <= {shreg[6:0], sda_in};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (state == I2C_RACK && sda_in) begin
        state <= I2C_IDLE;
      end
    end else if (scl_fall) begin
      unique case (state)
        I2C_IDLE: begin
        end
        I2C_ADDR: begin
          if (bit_cnt == 4'h8) begin
            if (shreg[7:1] == DEV_ADDR) begin
              drive_low <= 1'b1;
              rw        <= shreg[0];
              state     <= I2C_AACK;
            end else begin
              state <= I2C_IDLE;
            end
          end
        end
        I2C_AACK, I2C_RACK: begin
          if (state == I2C_RACK || rw) begin
            drive_low <= !rd_data[7];
            shreg     <= {rd_data[6:0], 1'b0};
            bit_cnt   <= 4'h1;
            state     <= I2C_RD;
          end else begin
            drive_low <= 1'b0;
            bit_cnt   <= 4'h0;
            state     <= I2C_WR;
          end
        end
        I2C_WR: begin
          if (bit_cnt == 4'h8) begin
            drive_low <= 1'b1;
            state     <= I2C_WACK;
            if (first) begin
              ptr   <= shreg[6:0];
              first <= 1'b0;
            end else begin
              bus_req.wr   <= 1'b1;
              bus_req.addr <= ptr;
              bus_req.data <= shreg;
              ptr          <= ptr + 7'h01;
            end
          end
        end
        I2C_WACK: begin
          drive_low <= 1'b0;
          bit_cnt   <= 4'h0;
          state     <= I2C_WR;
        end
        I2C_RD: begin
          if (bit_cnt == 4'h8) begin
            drive_low <= 1'b0;
            ptr       <= ptr + 7'h01;
            state     <= I2C_RACK;
          end else begin
            drive_low <= !shreg[7];
            shreg     <= {shreg[6:0], 1'b0};
            bit_cnt   <= bit_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  assign prog_idx = bus_req.addr - `PROG_FIRST_OFS;
  assign prog_hit = bus_req.wr
                    && bus_req.addr >= `PROG_FIRST_OFS
                    && bus_req.addr <= `PROG_LAST_OFS;

  // read mux, unmapped addresses read as zero
  always_comb begin
    logic [6:0] ridx;
    ridx    = ptr - `PROG_FIRST_OFS;
    rd_data = 8'h00;
    if (ptr == `RUN_CTRL_OFS) begin
      rd_data = run_ctrl_reg;
    end else if (ptr == `MODE_SEL_OFS) begin
      rd_data = mode_sel_reg;
    end else if (ptr >= `RED_DUTY_OFS && ptr < `RED_DRIVE_OFS) begin
      rd_data = duty_reg[2'(ptr - `RED_DUTY_OFS)];
    end else if (ptr >= `RED_DRIVE_OFS && ptr < `RED_DRIVE_OFS + 7'h02) begin
      rd_data = drive_reg[1'(ptr - `RED_DRIVE_OFS)];
    end else if (ptr >= `PROG_FIRST_OFS && ptr <= `PROG_LAST_OFS) begin
      rd_data = prog_mem[ridx];
    end
  end

  // host write wins over the engine's return to hold
  always_comb begin
    run_ctrl_next = run_ctrl_reg;
    if (bus_req.wr && bus_req.addr == `RUN_CTRL_OFS) begin
      run_ctrl_next = bus_req.data;
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        if (hold_req[c]) begin
          run_ctrl_next[(`RED_FIELD_LSB - 2*c) +: 2] = EXEC_HOLD;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      run_ctrl_reg <= `RUN_CTRL_RST;
    end else begin
      run_ctrl_reg <= run_ctrl_next;
    end
  end

  always_comb begin
    for (int c = 0; c < CHANS; c++) begin
      mode_chg[c] = bus_req.wr && bus_req.addr == `MODE_SEL_OFS
                    && chan_field(bus_req.data, 2'(c))
                       != chan_field(mode_sel_reg, 2'(c));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_sel_reg <= `MODE_SEL_RST;
    end else if (bus_req.wr && bus_req.addr == `MODE_SEL_OFS) begin
      mode_sel_reg <= bus_req.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int c = 0; c < CHANS; c++) begin
        duty_reg[c] <= `DUTY_RST;
      end
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        if (bus_req.wr && bus_req.addr == 7'(`RED_DUTY_OFS + c)) begin
          duty_reg[c] <= bus_req.data;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      drive_reg[0] <= `DRIVE_RST;
      drive_reg[1] <= `DRIVE_RST;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (bus_req.wr && bus_req.addr == 7'(`RED_DRIVE_OFS + c)) begin
          drive_reg[c] <= bus_req.data;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (prog_hit
        && chan_field(mode_sel_reg, prog_idx[6:5]) == MODE_LOAD) begin
      prog_mem[prog_idx] <= bus_req.data;
    end
  end

  for (genvar c = 0; c < CHANS; c++) begin : g_chan
    channel_engine #(
      .INSTR_CYCLES (INSTR_CYCLES)
    ) u_engine (
      .sys_clk      (sys_clk),
      .nrst         (rst_n),
      .enable       (chip_en),
      .mode         (mode_type'(chan_field(mode_sel_reg, 2'(c)))),
      .exec         (exec_type'(chan_field(run_ctrl_reg, 2'(c)))),
      .mode_change  (mode_chg[c]),
      .instr        (prog_mem[{2'(c), pc[c], 1'b1}]),
      .prog_counter (pc[c]),
      .hold_req     (hold_req[c]),
      .duty         (eng_duty[c])
    );
  end

  // output duty per channel mode
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int c = 0; c < CHANS; c++) begin
        duty_out[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < CHANS; c++) begin
        if (!chip_en) begin
          duty_out[c] <= 8'h00;
        end else begin
          unique case (mode_type'(chan_field(mode_sel_reg, 2'(c))))
            MODE_DIRECT: duty_out[c] <= duty_reg[c];
            MODE_RUN:    duty_out[c] <= eng_duty[c];
            MODE_OFF:    duty_out[c] <= 8'h00;
            MODE_LOAD:   duty_out[c] <= 8'h00;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      red_current   <= 8'h00;
      green_current <= 8'h00;
      chip_active   <= 1'b0;
    end else begin
      red_current   <= log_en ? log_map(drive_reg[0]) : drive_reg[0];
      green_current <= log_en ? log_map(drive_reg[1]) : drive_reg[1];
      chip_active   <= chip_en;
    end
  end

  assign red_duty           = duty_out[0];
  assign green_duty         = duty_out[1];
  assign blue_duty          = duty_out[2];
  assign red_prog_counter   = pc[0];
  assign green_prog_counter = pc[1];
  assign blue_prog_counter  = pc[2];

endmodule : led_channel_control_regs
`default_nettype wire

// ==== shared/led_chan_consts.svh ====
`ifndef LED_CHAN_CONSTS_SVH
`define LED_CHAN_CONSTS_SVH

// register offsets
`define RUN_CTRL_OFS      7'h00
`define MODE_SEL_OFS      7'h01
`define RED_DUTY_OFS      7'h02
`define RED_DRIVE_OFS     7'h05
`define PROG_FIRST_OFS    7'h10
`define PROG_LAST_OFS     7'h6f

// field positions
`define LOG_EN_BIT        7
`define CHIP_EN_BIT       6
`define RED_FIELD_LSB     4
`define GREEN_FIELD_LSB   2
`define BLUE_FIELD_LSB    0

// reset values
`define RUN_CTRL_RST      8'h00
`define MODE_SEL_RST      8'h00
`define DUTY_RST          8'h00
`define DRIVE_RST         8'haf

// bus address, arbitrary value
`define DEV_ADDR_DFLT     7'h2a

// instruction length in clock cycles
`define INSTR_CYCLES_DFLT 16

`endif

// ==== shared/led_chan_pkg.sv ====
package led_chan_pkg;

  typedef enum logic [1:0] {
    EXEC_HOLD     = 2'b00,
    EXEC_STEP     = 2'b01,
    EXEC_CONTINUE = 2'b10,
    EXEC_SINGLE   = 2'b11
  } exec_type;

  typedef enum logic [1:0] {
    MODE_OFF    = 2'b00,
    MODE_LOAD   = 2'b01,
    MODE_RUN    = 2'b10,
    MODE_DIRECT = 2'b11
  } mode_type;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_AACK, I2C_WR, I2C_WACK, I2C_RD, I2C_RACK
  } i2c_state_type;

  typedef struct packed {
    logic       wr;
    logic [6:0] addr;
    logic [7:0] data;
  } reg_req_type;

endpackage : led_chan_pkg

// ==== verilog/channel_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "led_chan_consts.svh"

module channel_engine #(
  parameter int INSTR_CYCLES = `INSTR_CYCLES_DFLT,
  parameter int CNT_W        = 8
) (
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  input  wire logic                  enable,
  input  wire led_chan_pkg::mode_type mode,
  input  wire led_chan_pkg::exec_type exec,
  input  wire logic                  mode_change,
  input  wire logic [7:0]            instr,
  output logic      [3:0]            prog_counter,
  output logic                       hold_req,
  output logic      [7:0]            duty
);
  import led_chan_pkg::*;

  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(INSTR_CYCLES - 1);

  logic             busy;
  logic [CNT_W-1:0] cnt;
  logic             running;
  logic             done;

  assign running  = enable && (mode == MODE_RUN) && !mode_change;
  assign done     = running && busy && (cnt == '0);
  assign hold_req = done && (exec == EXEC_STEP || exec == EXEC_SINGLE);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      busy         <= 1'b0;
      cnt          <= '0;
      prog_counter <= 4'h0;
      duty         <= 8'h00;
    end else if (mode_change) begin
      busy         <= 1'b0;
      cnt          <= '0;
      prog_counter <= 4'h0;
    end else if (!running) begin
      busy <= 1'b0;
    end else if (busy) begin
      if (cnt == '0) begin
        busy <= 1'b0;
        if (exec == EXEC_STEP || exec == EXEC_CONTINUE) begin
          prog_counter <= prog_counter + 4'h1;
        end
      end else begin
        cnt <= cnt - CNT_W'(1);
      end
    end else if (exec != EXEC_HOLD) begin
      busy <= 1'b1;
      cnt  <= CNT_LOAD;
      duty <= instr;
    end
  end

endmodule : channel_engine
`default_nettype wire

// ==== verification/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "led_chan_consts.svh"

module i2c_host_model #(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DFLT
) (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  output var logic  scl,
  output var logic  sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic half(input logic s, input int n);
    scl <= s;
    repeat (n) @(posedge sys_clk);
  endtask : half

  task automatic bit_io(input logic b, output logic r);
    sda_drv <= b;
    half(1'b0, 4);
    half(1'b1, 4);
    r = sda_line;
    half(1'b0, 2);
  endtask : bit_io

  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, ack);
  endtask : xfer

  // also serves as repeated start
  task automatic start;
    sda_drv <= 1'b1;
    half(1'b0, 4);
    half(1'b1, 4);
    sda_drv <= 1'b0;
    half(1'b1, 4);
    half(1'b0, 2);
  endtask : start

  task automatic stop;
    sda_drv <= 1'b0;
    half(1'b0, 4);
    half(1'b1, 4);
    sda_drv <= 1'b1;
    half(1'b1, 4);
  endtask : stop

  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                           input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic       k1, k2, k3;
    start;
    xfer({dev, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    xfer(d, 1'b1, q, k3);
    stop;
    nak = k1 | k2 | k3;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                          output logic nak);
    logic [7:0] q;
    logic       k1, k2, k3, k4;
    start;
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, k1);
    xfer(a, 1'b1, q, k2);
    start;
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, k3);
    xfer(8'hff, 1'b1, d, k4);
    stop;
    nak = k1 | k2 | k3;
  endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

// ==== verification/led_regs_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module led_regs_properties (
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic       en_pin,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic [7:0] red_duty,
  input wire logic [7:0] green_duty,
  input wire logic [7:0] blue_duty,
  input wire logic [7:0] red_current,
  input wire logic [7:0] green_current,
  input wire logic [3:0] red_prog_counter,
  input wire logic [3:0] blue_prog_counter,
  input wire logic       chip_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_pin_clears_enable: assert property (
    !en_pin [*2] |=> !chip_active)
    else $error("chip enable kept after enable pin low");
  chk_pin_clears_outputs: assert property (
    !en_pin [*2] |=> red_duty == 8'h00 && green_duty == 8'h00
      && blue_duty == 8'h00 && red_prog_counter == 4'h0
      && blue_prog_counter == 4'h0)
    else $error("outputs not cleared by enable pin low");
  chk_pin_resets_current: assert property (
    !en_pin ##1 en_pin |=> red_current == 8'haf && green_current == 8'haf)
    else $error("drive code not back to default");
  chk_current_after_reset: assert property (
    $rose(nrst) && en_pin |-> ##[1:2]
      (red_current == 8'haf && green_current == 8'haf))
    else $error("drive code wrong after reset");
  chk_idle_duty_zero: assert property (
    !chip_active [*3] |-> red_duty == 8'h00 && green_duty == 8'h00
      && blue_duty == 8'h00)
    else $error("duty driven while chip disabled");
  chk_pc_steps_one: assert property (
    $changed(red_prog_counter) |-> red_prog_counter == 4'h0
      || red_prog_counter == 4'($past(red_prog_counter) + 4'h1))
    else $error("program counter jumped");
  chk_sda_drive_low: assert property (
    !sda_oe_n |-> sda_out == 1'b0)
    else $error("data pin driven high");
  chk_sda_scl_low: assert property (
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("data drive changed near clock high");

  cover property (red_duty == 8'h11);
  cover property (red_prog_counter == 4'h3);
  cover property (!sda_oe_n && scl_in);
endmodule : led_regs_properties

bind led_channel_control_regs led_regs_properties led_regs_properties_i (
  .sys_clk(sys_clk), .nrst(nrst), .en_pin(en_pin), .scl_in(scl_in),
  .sda_out(sda_out), .sda_oe_n(sda_oe_n), .red_duty(red_duty),
  .green_duty(green_duty), .blue_duty(blue_duty),
  .red_current(red_current), .green_current(green_current),
  .red_prog_counter(red_prog_counter),
  .blue_prog_counter(blue_prog_counter),
  .chip_active(chip_active));
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "led_chan_consts.svh"

module tb_top;
  import led_chan_pkg::*;
  logic       sys_clk, nrst, en_pin, scl, host_sda, sda_out, sda_oe_n;
  logic       chip_active;
  logic [7:0] red_duty, green_duty, blue_duty, red_current, green_current;
  logic [3:0] red_prog_counter, green_prog_counter, blue_prog_counter;
  wire  logic sda_line;
  int         errors;
  int         tests_run;

  // open-drain data line with pull-up
  assign sda_line = host_sda & (sda_oe_n | sda_out);

  led_channel_control_regs #(.INSTR_CYCLES(2)) led_channel_control_regs_i (
    .sys_clk(sys_clk), .nrst(nrst), .en_pin(en_pin), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .red_duty(red_duty), .green_duty(green_duty), .blue_duty(blue_duty),
    .red_current(red_current), .green_current(green_current),
    .red_prog_counter(red_prog_counter),
    .green_prog_counter(green_prog_counter),
    .blue_prog_counter(blue_prog_counter), .chip_active(chip_active));
  i2c_host_model i2c_host_model_i (.sys_clk(sys_clk), .sda_line(sda_line),
    .scl(scl), .sda_drv(host_sda));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic nak;
    i2c_host_model_i.write_reg(`DEV_ADDR_DFLT, a, d, nak);
    check({7'h0, nak}, 8'h00);
  endtask : wr

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       nak;
    i2c_host_model_i.read_reg(a, d, nak);
    check({7'h0, nak}, 8'h00);
    check(d, exp);
  endtask : rd_check

  function automatic logic [7:0] log_code(input logic [7:0] c);
    logic [15:0] sq;
    sq = 16'(c) * 16'(c);
    return (c != 8'h00 && sq[15:8] == 8'h00) ? 8'h01 : sq[15:8];
  endfunction : log_code

  task automatic test_reset_values;
    logic [7:0] tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'haf,
                            8'haf, 8'h00};
    for (int a = 0; a < 8; a++) rd_check(8'(a), tab[a]);
    check(red_current, 8'haf);
    check(green_current, 8'haf);
  endtask : test_reset_values

  task automatic test_direct;
    logic [7:0] pat [3] = '{8'h5a, 8'ha5, 8'hff};
    mode_type   md [3] = '{MODE_OFF, MODE_LOAD, MODE_DIRECT};
    wr(8'h00, 8'h40);
    for (int a = 0; a < 3; a++) wr(8'(a + 2), pat[a]);
    for (int a = 0; a < 3; a++) rd_check(8'(a + 2), pat[a]);
    foreach (md[i]) begin
      wr(8'h01, {2'b00, md[i], MODE_DIRECT, MODE_OFF});
      check(red_duty, md[i] == MODE_DIRECT ? pat[0] : 8'h00);
      check(green_duty, pat[1]);
      check(blue_duty, 8'h00);
    end
    rd_check(8'h01, 8'h3c);
  endtask : test_direct

  task automatic test_current;
    wr(8'h05, 8'hff);
    wr(8'h06, 8'h05);
    check(red_current, 8'hff);
    check(green_current, 8'h05);
    wr(8'h00, 8'hc0);
    check(red_current, log_code(8'hff));
    check(green_current, log_code(8'h05));
    wr(8'h00, 8'h40);
    check(red_current, 8'hff);
  endtask : test_current

  task automatic test_engine;
    logic [3:0] pc;
    int         n;
    wr(8'h01, {2'b00, MODE_LOAD, 4'h0});
    for (int i = 0; i < 3; i++) wr(8'(8'h11 + 2 * i), 8'(8'h11 * (i + 1)));
    rd_check(8'h13, 8'h22);
    wr(8'h01, {2'b00, MODE_RUN, 4'h0});
    check({4'h0, red_prog_counter}, 8'h00);
    check({4'h0, green_prog_counter}, 8'h00);
    check({4'h0, blue_prog_counter}, 8'h00);
    wr(8'h00, {2'b01, EXEC_SINGLE, 4'h0});
    check(red_duty, 8'h11);
    check({4'h0, red_prog_counter}, 8'h00);
    rd_check(8'h00, 8'h40);
    wr(8'h00, {2'b01, EXEC_STEP, 4'h0});
    check({4'h0, red_prog_counter}, 8'h01);
    rd_check(8'h00, 8'h40);
    wr(8'h00, {2'b01, EXEC_CONTINUE, 4'h0});
    n = 0;
    while (red_prog_counter !== 4'h3 && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    check({4'h0, red_prog_counter}, 8'h03);
    if (n == 500)
      complete_run;
    wr(8'h00, {2'b01, EXEC_HOLD, 4'h0});
    pc = red_prog_counter;
    repeat (20) @(posedge sys_clk);
    check({4'h0, red_prog_counter}, {4'h0, pc});
    wr(8'h01, {2'b00, MODE_DIRECT, 4'h0});
    check({4'h0, red_prog_counter}, 8'h00);
    // program writes outside load mode are dropped
    wr(8'h13, 8'h99);
    rd_check(8'h13, 8'h22);
  endtask : test_engine

  task automatic test_pin;
    logic nak;
    check({7'h0, chip_active}, 8'h01);
    i2c_host_model_i.write_reg(`DEV_ADDR_DFLT ^ 7'h01, 8'h05, 8'h12, nak);
    check({7'h0, nak}, 8'h01);
    rd_check(8'h05, 8'hff);
    // no program running, so the pin may drop at once
    en_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    en_pin <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({7'h0, chip_active}, 8'h00);
    rd_check(8'h00, 8'h00);
    rd_check(8'h05, 8'haf);
  endtask : test_pin

  initial begin
    errors    = 0;
    tests_run = 0;
    nrst      = 1'b0;
    en_pin    = 1'b1;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    test_reset_values;
    test_direct;
    test_current;
    test_engine;
    test_pin;
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
